/* File: logic/swtq_pkg.sv */
// Constants and types for the sleep, wake and thermal qualifier.
// Assumes one standby clock and APB register access; pins arrive unsynchronised.
package swtq_pkg;
    // APB byte offsets
    localparam logic [7:0] OFF_CTRL  = 8'h00;
    localparam logic [7:0] OFF_THERM = 8'h04;
    localparam logic [7:0] OFF_STAT  = 8'h08;
    localparam logic [7:0] OFF_SRC   = 8'h0C;
    localparam logic [7:0] OFF_TEMP  = 8'h10;
    // Control register bit positions
    localparam int CB_ALARM  = 0;
    localparam int CB_PME    = 1;
    localparam int CB_DEVCAP = 2;
    localparam int CB_WOL    = 3;
    localparam int CB_USBPWR = 4;
    localparam int CB_USBEN  = 5;
    localparam int CB_AUTO   = 6;
    localparam int CTRL_W    = 7;
    localparam logic [6:0] CTRL_RST = 7'h00;
    // Thermal register fields
    localparam int TH_OFS_LSB  = 0;
    localparam int TH_CRIT_LSB = 8;
    localparam logic [7:0] OFS_RST  = 8'h00;
    localparam logic [7:0] CRIT_RST = 8'h69;
    // Status register fields
    localparam int SB_STATE_LSB = 0;
    localparam int SB_WAKE      = 4;
    localparam int SB_THR       = 5;
    localparam int SB_SHUT      = 6;
    localparam int SB_FAN_LSB   = 8;
    // Thermal figures in degrees C
    localparam logic [7:0] THR_BASE    = 8'h64;
    localparam logic [7:0] TMAX_DEF    = 8'h64;
    localparam logic [7:0] AUTO_MARGIN = 8'h05;
    localparam logic [7:0] FAN_START   = 8'h28;
    localparam logic [3:0] FAN_GAIN    = 4'h4;
    // Wake source indices
    localparam int SRC_PWRBTN  = 0;
    localparam int SRC_SMB     = 1;
    localparam int SRC_PCIE    = 2;
    localparam int SRC_WDT     = 3;
    localparam int SRC_CARRIER = 4;
    localparam int SRC_PME     = 5;
    localparam int SRC_LAN     = 6;
    localparam int SRC_USB     = 7;
    localparam int SRC_RTC     = 8;
    localparam int SRC_N       = 9;
    // Sleep state code from the sequencer
    localparam logic [1:0] SLP_S0 = 2'h0;
    localparam logic [1:0] SLP_S3 = 2'h1;
    localparam logic [1:0] SLP_S4 = 2'h2;
    localparam logic [1:0] SLP_S5 = 2'h3;
    typedef enum logic [3:0] {
        ST_S0 = 4'b0001,
        ST_S3 = 4'b0010,
        ST_S4 = 4'b0100,
        ST_S5 = 4'b1000
    } swtq_state_t;
    // Wake sources, active high, order matches the indices
    typedef struct packed {
        logic rtc_alarm;
        logic usb;
        logic lan;
        logic pme;
        logic carrier_wake;
        logic wdt_button;
        logic pcie_wake;
        logic smb_alert;
        logic power_button;
    } swtq_src_t;
endpackage

/* File: logic/swtq_top.sv */
// Wake source qualification, throttle, fan and critical trip for the standby domain.
// Assumes sleep code and temperature come from logic on mclk_i; wake pins are asynchronous.
`timescale 1ns/1ps
// Contract
// - Button, alert, PCIe, watchdog wake S3-S5 always
// - Carrier wake honoured only in S3
// - RTC alarm wakes only S5 when enabled
// - PME wakes when resume or capability enabled
// - LAN wake only with wake-on-LAN configured
// - USB wakes S3 with standby power, enable
// - Throttle at 100 minus offset
// - Automatic trip at maximum plus five
// - Fan speed follows CPU temperature
// - Critical trip forces orderly shutdown
// - Track S3, S4, S5 sleep state
module swtq_top #(
    parameter logic [7:0] TMAX = swtq_pkg::TMAX_DEF
) (
    input  wire swtq_pkg::swtq_src_t wake_src_i,
    input  wire logic                mclk_i,
    input  wire logic                nrst_i,
    input  wire logic                ce_i,
    input  wire logic [1:0]          sleep_code_i,
    input  wire logic [7:0]          cpu_temp_i,
    input  wire logic                psel_i,
    input  wire logic                penable_i,
    input  wire logic                pwrite_i,
    input  wire logic [7:0]          paddr_i,
    input  wire logic [31:0]         pwdata_i,
    output logic      [31:0]         prdata_o,
    output logic                     pready_o,
    output logic                     pslverr_o,
    output logic                     wake_o,
    output logic                     throttle_o,
    output logic                     shutdown_o,
    output logic      [7:0]          fan_duty_o
);
    localparam int N = swtq_pkg::SRC_N;

    // Synchroniser chain; the edge detector reads stage two and the delayed copy only
    logic [N-1:0] sync1;
    logic [N-1:0] sync2;
    logic [N-1:0] sync3;
    logic [N-1:0] rise;
    logic [N-1:0] src_vec;
    assign src_vec = wake_src_i;

    genvar gi;
    generate
        for (gi = 0; gi < N; gi++)
        begin : g_sync
            always_ff @(posedge mclk_i)
            begin
                if (!nrst_i)
                begin
                    sync1[gi] <= 1'b0;
                    sync2[gi] <= 1'b0;
                    sync3[gi] <= 1'b0;
                end
                else if (ce_i)
                begin
                    sync1[gi] <= src_vec[gi];
                    sync2[gi] <= sync1[gi];
                    sync3[gi] <= sync2[gi];
                end
            end
            assign rise[gi] = sync2[gi] & ~sync3[gi];
        end
    endgenerate

    // Sleep state tracking
    swtq_pkg::swtq_state_t state;
    swtq_pkg::swtq_state_t next_state;
    always_comb
    begin
        unique case (sleep_code_i)
            swtq_pkg::SLP_S3: next_state = swtq_pkg::ST_S3;
            swtq_pkg::SLP_S4: next_state = swtq_pkg::ST_S4;
            swtq_pkg::SLP_S5: next_state = swtq_pkg::ST_S5;
            default:          next_state = swtq_pkg::ST_S0;
        endcase
    end
    always_ff @(posedge mclk_i)
    begin
        if (!nrst_i)
            state <= swtq_pkg::ST_S0;
        else if (ce_i)
            state <= next_state;
    end

    logic in_sleep;
    logic in_s3;
    logic in_s5;
    assign in_sleep = (state != swtq_pkg::ST_S0);
    assign in_s3    = (state == swtq_pkg::ST_S3);
    assign in_s5    = (state == swtq_pkg::ST_S5);

    // Software state
    logic [swtq_pkg::CTRL_W-1:0] ctrl;
    logic [7:0]                  ofs;
    logic [7:0]                  crit;
    logic [N-1:0]                src_seen;
    logic [swtq_pkg::CTRL_W-1:0] next_ctrl;
    logic [7:0]                  next_ofs;
    logic [7:0]                  next_crit;
    logic [N-1:0]                next_src_seen;

    // Per source qualification against state and enables
    logic [N-1:0] qual;
    always_comb
    begin
        qual = '0;
        qual[swtq_pkg::SRC_PWRBTN]  = rise[swtq_pkg::SRC_PWRBTN] & in_sleep;
        qual[swtq_pkg::SRC_SMB]     = rise[swtq_pkg::SRC_SMB] & in_sleep;
        qual[swtq_pkg::SRC_PCIE]    = rise[swtq_pkg::SRC_PCIE] & in_sleep;
        qual[swtq_pkg::SRC_WDT]     = rise[swtq_pkg::SRC_WDT] & in_sleep;
        qual[swtq_pkg::SRC_CARRIER] = rise[swtq_pkg::SRC_CARRIER] & in_s3;
        qual[swtq_pkg::SRC_RTC]     = rise[swtq_pkg::SRC_RTC] & in_s5 & ctrl[swtq_pkg::CB_ALARM];
        qual[swtq_pkg::SRC_PME]     = rise[swtq_pkg::SRC_PME] & in_sleep
                                    & (ctrl[swtq_pkg::CB_PME] | ctrl[swtq_pkg::CB_DEVCAP]);
        qual[swtq_pkg::SRC_LAN]     = rise[swtq_pkg::SRC_LAN] & in_sleep & ctrl[swtq_pkg::CB_WOL];
        // USB wake needs the hub still powered in S3, else the event never reaches us
        qual[swtq_pkg::SRC_USB]     = rise[swtq_pkg::SRC_USB] & in_s3
                                    & ctrl[swtq_pkg::CB_USBPWR] & ctrl[swtq_pkg::CB_USBEN];
    end

    // Thresholds
    logic [7:0]  thr_temp;
    logic [7:0]  crit_temp;
    logic [11:0] fan_prod;
    logic [7:0]  fan_calc;
    assign thr_temp  = (ofs > swtq_pkg::THR_BASE) ? 8'h00 : 8'(swtq_pkg::THR_BASE - ofs);
    assign crit_temp = ctrl[swtq_pkg::CB_AUTO] ? 8'(TMAX + swtq_pkg::AUTO_MARGIN) : crit;
    // Linear ramp above the start point, saturated at full speed
    always_comb
    begin
        // Both factors widened first, else the product wraps at 8 bits and hot reads as cool
        fan_prod = 12'(cpu_temp_i - swtq_pkg::FAN_START) * 12'(swtq_pkg::FAN_GAIN);
        if (cpu_temp_i <= swtq_pkg::FAN_START)
            fan_calc = 8'h00;
        else if (fan_prod > 12'h0FF)
            fan_calc = 8'hFF;
        else
            fan_calc = fan_prod[7:0];
    end

    // Core outputs
    logic       next_wake;
    logic       next_thr;
    logic       next_shut;
    logic [7:0] next_fan;
    always_comb
    begin
        next_wake = in_sleep & (wake_o | (|qual));
        next_thr  = (cpu_temp_i >= thr_temp);
        // Shutdown request holds until the sequencer has taken the system down
        next_shut = ~in_sleep & (shutdown_o | (cpu_temp_i >= crit_temp));
        next_fan  = fan_calc;
    end
    always_ff @(posedge mclk_i)
    begin
        if (!nrst_i)
        begin
            wake_o     <= 1'b0;
            throttle_o <= 1'b0;
            shutdown_o <= 1'b0;
            fan_duty_o <= 8'h00;
        end
        else if (ce_i)
        begin
            wake_o     <= next_wake;
            throttle_o <= next_thr;
            shutdown_o <= next_shut;
            fan_duty_o <= next_fan;
        end
    end

    // APB decode; one wait state so read data also comes from a flop
    logic        acc;
    logic        wr_fire;
    logic        hit;
    logic [31:0] rd_mux;
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;
    assign acc     = psel_i & penable_i;
    assign wr_fire = acc & pready_o & pwrite_i;
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        hit    = 1'b1;
        unique case (paddr_i)
            swtq_pkg::OFF_CTRL:  rd_mux[swtq_pkg::CTRL_W-1:0] = ctrl;
            swtq_pkg::OFF_THERM:
            begin
                rd_mux[swtq_pkg::TH_OFS_LSB +: 8]  = ofs;
                rd_mux[swtq_pkg::TH_CRIT_LSB +: 8] = crit;
            end
            swtq_pkg::OFF_STAT:
            begin
                rd_mux[swtq_pkg::SB_STATE_LSB +: 4] = state;
                rd_mux[swtq_pkg::SB_WAKE]           = wake_o;
                rd_mux[swtq_pkg::SB_THR]            = throttle_o;
                rd_mux[swtq_pkg::SB_SHUT]           = shutdown_o;
                rd_mux[swtq_pkg::SB_FAN_LSB +: 8]   = fan_duty_o;
            end
            swtq_pkg::OFF_SRC:   rd_mux[N-1:0] = src_seen;
            swtq_pkg::OFF_TEMP:  rd_mux[7:0]   = cpu_temp_i;
            default:             hit           = 1'b0;
        endcase
        next_pready  = acc & ~pready_o;
        next_prdata  = (acc & ~pready_o & ~pwrite_i) ? rd_mux : 32'h0000_0000;
        next_pslverr = acc & ~pready_o & ~hit;
    end
    always_ff @(posedge mclk_i)
    begin
        if (!nrst_i)
        begin
            pready_o  <= 1'b0;
            prdata_o  <= 32'h0000_0000;
            pslverr_o <= 1'b0;
        end
        else if (ce_i)
        begin
            pready_o  <= next_pready;
            prdata_o  <= next_prdata;
            pslverr_o <= next_pslverr;
        end
    end

    // Register writes; a new source event wins over a write-one clear
    always_comb
    begin
        next_ctrl     = ctrl;
        next_ofs      = ofs;
        next_crit     = crit;
        next_src_seen = src_seen;
        if (wr_fire && paddr_i == swtq_pkg::OFF_CTRL)
            next_ctrl = pwdata_i[swtq_pkg::CTRL_W-1:0];
        if (wr_fire && paddr_i == swtq_pkg::OFF_THERM)
        begin
            next_ofs  = pwdata_i[swtq_pkg::TH_OFS_LSB +: 8];
            next_crit = pwdata_i[swtq_pkg::TH_CRIT_LSB +: 8];
        end
        if (wr_fire && paddr_i == swtq_pkg::OFF_SRC)
            next_src_seen = src_seen & ~pwdata_i[N-1:0];
        next_src_seen = next_src_seen | qual;
    end
    always_ff @(posedge mclk_i)
    begin
        if (!nrst_i)
        begin
            ctrl     <= swtq_pkg::CTRL_RST;
            ofs      <= swtq_pkg::OFS_RST;
            crit     <= swtq_pkg::CRIT_RST;
            src_seen <= '0;
        end
        else if (ce_i)
        begin
            ctrl     <= next_ctrl;
            ofs      <= next_ofs;
            crit     <= next_crit;
            src_seen <= next_src_seen;
        end
    end

    // Checks on the qualification and thermal paths
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);

    // An unconditional source must reach the merged output one cycle on
    a_button_wakes: assert property (
        ce_i && in_sleep && next_state != swtq_pkg::ST_S0 && rise[swtq_pkg::SRC_PWRBTN] |=> wake_o)
        else $error("button did not wake");
    // Gated sources never pass outside their state or without their enables
    a_carrier_s3only: assert property (
        qual[swtq_pkg::SRC_CARRIER] |-> state == swtq_pkg::ST_S3)
        else $error("carrier wake outside S3");
    a_rtc_gated: assert property (
        qual[swtq_pkg::SRC_RTC] |-> in_s5 && ctrl[swtq_pkg::CB_ALARM])
        else $error("rtc wake not gated");
    a_pme_gated: assert property (
        qual[swtq_pkg::SRC_PME] |-> ctrl[swtq_pkg::CB_PME] || ctrl[swtq_pkg::CB_DEVCAP])
        else $error("pme wake not gated");
    a_lan_gated: assert property (
        qual[swtq_pkg::SRC_LAN] |-> ctrl[swtq_pkg::CB_WOL])
        else $error("lan wake not gated");
    a_usb_gated: assert property (
        qual[swtq_pkg::SRC_USB] |-> in_s3 && ctrl[swtq_pkg::CB_USBPWR] && ctrl[swtq_pkg::CB_USBEN])
        else $error("usb wake not gated");
    // Thermal thresholds and the fan ramp end points
    a_throttle_zero: assert property (
        ce_i && ofs == 8'h00 && cpu_temp_i == swtq_pkg::THR_BASE |=> throttle_o)
        else $error("no throttle at base");
    a_auto_trip: assert property (
        ctrl[swtq_pkg::CB_AUTO] |-> crit_temp == 8'(TMAX + swtq_pkg::AUTO_MARGIN))
        else $error("auto trip wrong");
    a_fan_idle: assert property (
        ce_i && cpu_temp_i <= swtq_pkg::FAN_START |=> fan_duty_o == 8'h00)
        else $error("fan runs when cool");
    // With a gain of four, any step past 63 above the start must saturate
    a_fan_full: assert property (
        ce_i && cpu_temp_i > 8'(swtq_pkg::FAN_START + 8'h3F) |=> fan_duty_o == 8'hFF)
        else $error("fan not saturated");
    // Trip request stays up until the sequencer has left the awake state
    a_shut_hold: assert property (
        ce_i && shutdown_o && !in_sleep && next_state == swtq_pkg::ST_S0
        |=> shutdown_o [*2] or ##1 !ce_i || in_sleep)
        else $error("shutdown dropped");
    a_state_s4: assert property (
        ce_i && sleep_code_i == swtq_pkg::SLP_S4 |=> state == swtq_pkg::ST_S4)
        else $error("state not tracked");
    a_wake_clear: assert property (
        ce_i && !in_sleep |=> !wake_o)
        else $error("wake held awake");
endmodule // swtq_top

/* File: tb/swtq_seq_model.sv */
// Behavioural power sequencer that sits beyond the qualifier's wake and trip outputs.
// Assumes the bench commands sleep entry; wake and trip come from the design on mclk_i.
`timescale 1ns/1ps
module swtq_seq_model (
    input  wire logic       mclk_i,
    input  wire logic       nrst_i,
    input  wire logic       go_i,
    input  wire logic [1:0] tgt_i,
    input  wire logic [3:0] dly_i,
    input  wire logic       wake_i,
    input  wire logic       shutdown_i,
    output logic      [1:0] sleep_code_o
);
    logic [3:0] cnt;
    // Command first, then orderly power-off on trip, then resume after a chosen delay
    always_ff @(posedge mclk_i)
    begin
        if (!nrst_i)
        begin
            sleep_code_o <= swtq_pkg::SLP_S0;
            cnt          <= 4'h0;
        end
        else if (go_i)
            sleep_code_o <= tgt_i;
        else if (shutdown_i && sleep_code_o == swtq_pkg::SLP_S0)
            sleep_code_o <= swtq_pkg::SLP_S5; // Soft-off answers the trip
        else if (wake_i && sleep_code_o != swtq_pkg::SLP_S0)
        begin
            // A slow sequencer keeps the wake request standing for longer
            if (cnt >= dly_i)
            begin
                sleep_code_o <= swtq_pkg::SLP_S0;
                cnt          <= 4'h0;
            end
            else
                cnt <= cnt + 4'h1;
        end
    end
endmodule // swtq_seq_model

/* File: tb/swtq_tb_top.sv */
// Self-checking bench for the wake, throttle, fan and trip qualifier.
// Assumes one 125 MHz clock; the sequencer model closes the wake and trip loops.
`timescale 1ns/1ps
module swtq_tb_top;
    localparam logic [7:0] TMAX_TB = 8'h5A;
    logic mclk_i = 1'b0, nrst_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic go = 1'b0, pready, pslverr, wake_o, throttle_o, shutdown_o;
    logic [1:0] tgt = 2'h0, sleep_code;
    logic [3:0] dly = 4'h0;
    logic [7:0] paddr = 8'h00, temp = 8'h19, fan_duty_o;
    logic [31:0] pwdata = 32'h0000_0000, prdata, r;
    logic e;
    swtq_pkg::swtq_src_t wake_src = '0;
    int fails = 0, check_count = 0;

    always #4 mclk_i = ~mclk_i;

    swtq_top #(.TMAX(TMAX_TB)) dut (.wake_src_i(wake_src), .mclk_i(mclk_i), .nrst_i(nrst_i), .ce_i(1'b1),
        .sleep_code_i(sleep_code), .cpu_temp_i(temp), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .wake_o(wake_o), .throttle_o(throttle_o), .shutdown_o(shutdown_o),
        .fan_duty_o(fan_duty_o));
    swtq_seq_model seq (.mclk_i(mclk_i), .nrst_i(nrst_i), .go_i(go), .tgt_i(tgt), .dly_i(dly),
        .wake_i(wake_o), .shutdown_i(shutdown_o), .sleep_code_o(sleep_code));

    task automatic complete_run();
        if (fails == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            fails++;
        end
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk_i);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge mclk_i);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge mclk_i); n++; end while (pready !== 1'b1 && n < 50);
        if (n >= 50) fails++;
        r = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    task automatic sleep_to(input logic [1:0] st);
        @(posedge mclk_i);
        go <= 1'b1; tgt <= st;
        @(posedge mclk_i);
        go <= 1'b0;
        repeat (4) @(posedge mclk_i);
    endtask

    // Reset values, read-only status, and an unmapped address refused
    task automatic reset_regs();
        logic [7:0]  a [6] = '{swtq_pkg::OFF_CTRL, swtq_pkg::OFF_THERM, swtq_pkg::OFF_STAT,
                               swtq_pkg::OFF_SRC, swtq_pkg::OFF_TEMP, 8'h20};
        logic [31:0] x [6] = '{32'h0000_0000, {16'h0000, swtq_pkg::CRIT_RST, swtq_pkg::OFS_RST},
                               32'h0000_0001, 32'h0000_0000, 32'h0000_0019, 32'h0000_0000};
        apb(1'b1, 8'h20, 32'hFFFF_FFFF);
        apb(1'b1, swtq_pkg::OFF_STAT, 32'h0000_00FF);
        for (int i = 0; i < 6; i++)
        begin
            apb(1'b0, a[i], 32'h0000_0000);
            chk(r, x[i]);
            chk(32'(e), (i == 5) ? 32'h0000_0001 : 32'h0000_0000);
        end
    endtask

    function automatic logic exp_q(int s, logic [1:0] st, logic [6:0] c);
        case (s)
            swtq_pkg::SRC_CARRIER: return st == swtq_pkg::SLP_S3;
            swtq_pkg::SRC_PME:     return c[swtq_pkg::CB_PME] | c[swtq_pkg::CB_DEVCAP];
            swtq_pkg::SRC_LAN:     return c[swtq_pkg::CB_WOL];
            swtq_pkg::SRC_USB:     return st == swtq_pkg::SLP_S3 && c[swtq_pkg::CB_USBPWR] && c[swtq_pkg::CB_USBEN];
            swtq_pkg::SRC_RTC:     return st == swtq_pkg::SLP_S5 && c[swtq_pkg::CB_ALARM];
            default:               return 1'b1;
        endcase
    endfunction

    // One source pulsed in one sleep state under one enable setting
    task automatic wake_case(input logic [1:0] st, input logic [6:0] c, input int s);
        logic q, seen;
        q = exp_q(s, st, c);
        seen = 1'b0;
        apb(1'b1, swtq_pkg::OFF_CTRL, {25'h000_0000, c});
        sleep_to(st);
        apb(1'b0, swtq_pkg::OFF_STAT, 32'h0000_0000);
        chk(r & 32'h0000_000F, 32'h0000_0001 << st);
        dly <= s[0] ? 4'h6 : 4'h0;
        wake_src <= swtq_pkg::swtq_src_t'(9'h001 << s);
        for (int i = 0; i < 10; i++)
        begin
            @(posedge mclk_i);
            if (i == 3) wake_src <= '0;
            if (wake_o === 1'b1) seen = 1'b1;
        end
        chk(32'(seen), 32'(q));
        if (!q) sleep_to(swtq_pkg::SLP_S0);
        repeat (20) @(posedge mclk_i);
        chk(32'(wake_o), 32'h0000_0000);
        apb(1'b0, swtq_pkg::OFF_SRC, 32'h0000_0000);
        chk(r, q ? (32'h0000_0001 << s) : 32'h0000_0000);
        apb(1'b1, swtq_pkg::OFF_SRC, 32'h0000_01FF);
    endtask

    // Throttle threshold and fan curve over boundary temperatures
    task automatic thermal();
        logic [7:0] o [8] = '{8'h00, 8'h00, 8'h0A, 8'h0A, 8'h00, 8'h00, 8'h00, 8'h00};
        logic [7:0] t [8] = '{8'h63, 8'h64, 8'h59, 8'h5A, 8'h28, 8'h29, 8'h67, 8'h68};
        logic [7:0] fe;
        for (int i = 0; i < 8; i++)
        begin
            apb(1'b1, swtq_pkg::OFF_THERM, {16'h0000, 8'hFF, o[i]});
            temp <= t[i];
            repeat (4) @(posedge mclk_i);
            fe = (t[i] <= swtq_pkg::FAN_START) ? 8'h00 : ((t[i] - swtq_pkg::FAN_START) > 8'h3F) ? 8'hFF :
                 8'((t[i] - swtq_pkg::FAN_START) * 8'(swtq_pkg::FAN_GAIN));
            chk(32'(throttle_o), 32'(t[i] >= (swtq_pkg::THR_BASE - o[i])));
            chk(32'(fan_duty_o), 32'(fe));
        end
        temp <= 8'h19;
    endtask

    // Programmed trip, orderly power-off, then the automatic trip point
    task automatic crit_trip();
        logic seen;
        seen = 1'b0;
        apb(1'b1, swtq_pkg::OFF_CTRL, 32'h0000_0000);
        apb(1'b1, swtq_pkg::OFF_THERM, 32'h0000_5000);
        temp <= 8'h4F;
        repeat (4) @(posedge mclk_i);
        chk(32'(shutdown_o), 32'h0000_0000);
        temp <= 8'h50;
        for (int i = 0; i < 6; i++)
        begin
            @(posedge mclk_i);
            if (shutdown_o === 1'b1) seen = 1'b1;
        end
        chk(32'(seen), 32'h0000_0001);
        temp <= 8'h19;
        repeat (10) @(posedge mclk_i);
        chk(32'(shutdown_o), 32'h0000_0000);
        sleep_to(swtq_pkg::SLP_S0);
        apb(1'b1, swtq_pkg::OFF_CTRL, 32'h0000_0040);
        temp <= TMAX_TB + swtq_pkg::AUTO_MARGIN - 8'h01;
        repeat (4) @(posedge mclk_i);
        chk(32'(shutdown_o), 32'h0000_0000);
        temp <= TMAX_TB + swtq_pkg::AUTO_MARGIN;
        repeat (4) @(posedge mclk_i);
        chk(32'(shutdown_o), 32'h0000_0001);
    endtask

    // Watchdog well beyond the few thousand cycles the sequence needs
    initial
    begin
        repeat (40000) @(posedge mclk_i);
        fails++;
        complete_run();
    end

    initial
    begin
        logic [6:0] cfg [3] = '{7'h00, 7'h3F, 7'h14};
        repeat (3) @(posedge mclk_i);
        nrst_i <= 1'b1;
        reset_regs();
        for (int c = 0; c < 3; c++)
            for (int st = 1; st < 4; st++)
                for (int s = 0; s < swtq_pkg::SRC_N; s++)
                    wake_case(2'(st), cfg[c], s);
        thermal();
        crit_trip();
        complete_run();
    end
endmodule // swtq_tb_top
